// File: logic/sync_edge_pkg.sv
// constants, field layout and carrier types for the sync edge sense and pulse width decoder
// assumes a 32-bit APB slave on ref_clk; all offsets are byte addresses
package sync_edge_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_EDGE_SENSE = 8'h00;
  localparam logic [7:0] OFF_MODULE_STOP = 8'h04;
  localparam logic [7:0] OFF_DECODE_CTRL = 8'h08;
  localparam logic [7:0] OFF_COMPARE_B = 8'h0C;
  localparam logic [7:0] OFF_MASK_OFFSET = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ****************************************
  // edge sense fields
  // ****************************************
  localparam int BIT_COMPOSITE = 5;
  localparam int BIT_HFLYBACK = 4;
  localparam int BIT_VFLYBACK = 3;
  localparam int BIT_PREEQ = 2;
  localparam int BIT_HLEVEL = 1;
  localparam int BIT_VLEVEL = 0;
  // ****************************************
  // module stop fields and reset
  // ****************************************
  localparam logic [15:0] MODULE_STOP_RESET = 16'h3FFF;
  localparam int BIT_FREE_TIMER_STOP = 13;
  localparam int BIT_TIMER01_STOP = 12;
  localparam int BIT_TIMERXY_STOP = 8;
  // ****************************************
  // decode control fields and reset values
  // ****************************************
  localparam int BIT_INV_H = 0;
  localparam int BIT_INV_V = 1;
  localparam int BIT_CORRECT = 2;
  localparam int POS_CLEAR_SEL = 3;
  localparam int POS_CLOCK_SEL = 5;
  localparam logic [1:0] CLEAR_ON_RISE = 2'h3;
  localparam logic [2:0] CLOCK_SYSTEM = 3'h1;
  localparam logic [7:0] DECODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_B_RESET = 8'hFF;
  localparam logic [7:0] MASK_OFFSET_RESET = 8'hFF;
  localparam int BIT_STAT_DECODED = 8;
  localparam int BIT_STAT_MASK = 9;
  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic composite_sync_pin;
    logic horiz_flyback_pin;
    logic vert_flyback_pin;
    logic hsync_pin;
    logic vsync_pin;
  } sync_pins_t;
  typedef struct packed {
    logic free_timer;
    logic timer01;
    logic timerxy_connection;
  } stop_out_t;
endpackage

// File: logic/sync_edge_decoder.sv
// sync edge sense flags, module stop control and pulse width decoder
// assumes sync pins are asynchronous and the APB master sits on ref_clk
`timescale 1ns/1ps
module sync_edge_decoder
  import sync_edge_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hw_standby,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sync pins
  input wire sync_pins_t pins,
  // results
  output stop_out_t module_stopped,
  output logic decoded_pulse_output,
  output logic horiz_corrected
);

  // ****************************************
  // helpers
  // ****************************************
  // address compare, used by read mux and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pin_s1; // first stage, read only by pin_s2
  logic [4:0] pin_s2; // safe level
  logic [4:0] pin_s3; // previous safe level for edges

  // two flops per pin, then one for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
    end else if (ce) begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] module_stop_control; // software view
  logic [7:0] decode_ctrl; // inversion, correction, clear and clock select
  logic [7:0] compare_b_register; // pulse width threshold
  logic [7:0] mask_offset_register; // mask interval offset
  logic [3:0] flags; // edge flags, bits 5..2 of edge sense
  logic [3:0] read_seen; // flag was read as 1 since last clear
  logic [3:0] set_ev; // flag set events this cycle
  logic internal_horiz_input;
  logic internal_vert_input;
  logic horiz_prev; // last horizontal level for edges
  logic [7:0] timer_counter; // decoder counter, also shown in status
  logic mask_active; // inside a mask interval
  logic acc_done; // access phase completes this edge
  logic wr_ok;
  logic rd_ok;

  assign acc_done = psel && penable && pready;
  assign wr_ok = acc_done && pwrite;
  assign rd_ok = acc_done && !pwrite;
  // software picks inversion so the horizontal signal is positive phase
  assign internal_horiz_input = pin_s2[1] ^ decode_ctrl[BIT_INV_H];
  assign internal_vert_input = pin_s2[0] ^ decode_ctrl[BIT_INV_V];

  // ****************************************
  // apb response
  // ****************************************
  logic [31:0] rd_mux;
  logic rd_err;

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit(paddr, OFF_EDGE_SENSE)) begin
      rd_mux[5:2] = flags;
      rd_mux[BIT_HLEVEL] = internal_horiz_input;
      rd_mux[BIT_VLEVEL] = internal_vert_input;
    end else if (hit(paddr, OFF_MODULE_STOP)) begin
      rd_mux[15:0] = module_stop_control;
    end else if (hit(paddr, OFF_DECODE_CTRL)) begin
      rd_mux[7:0] = decode_ctrl;
    end else if (hit(paddr, OFF_COMPARE_B)) begin
      rd_mux[7:0] = compare_b_register;
    end else if (hit(paddr, OFF_MASK_OFFSET)) begin
      rd_mux[7:0] = mask_offset_register;
    end else if (hit(paddr, OFF_STATUS)) begin
      rd_mux[7:0] = timer_counter;
      rd_mux[BIT_STAT_DECODED] = decoded_pulse_output;
      rd_mux[BIT_STAT_MASK] = mask_active;
    end else begin
      rd_err = 1'b1;
    end
  end

  // answer sampled in setup, ready in the first access cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= rd_err;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // plain read/write registers; hardware standby restores the stop default
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      module_stop_control <= MODULE_STOP_RESET;
      decode_ctrl <= DECODE_CTRL_RESET;
      compare_b_register <= COMPARE_B_RESET;
      mask_offset_register <= MASK_OFFSET_RESET;
    end else if (ce) begin
      if (hw_standby) begin
        module_stop_control <= MODULE_STOP_RESET;
      end else if (wr_ok && hit(paddr, OFF_MODULE_STOP)) begin
        module_stop_control <= pwdata[15:0];
      end
      if (wr_ok && hit(paddr, OFF_DECODE_CTRL)) begin
        decode_ctrl <= pwdata[7:0];
      end
      if (wr_ok && hit(paddr, OFF_COMPARE_B)) begin
        compare_b_register <= pwdata[7:0];
      end
      if (wr_ok && hit(paddr, OFF_MASK_OFFSET)) begin
        mask_offset_register <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // module stop, applied at bus cycle end
  // ****************************************
  // a stop only lands once the bus is idle, so a transfer in flight finishes first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      module_stopped <= 3'h7;
    end else if (ce && !psel) begin
      module_stopped.free_timer <= module_stop_control[BIT_FREE_TIMER_STOP];
      module_stopped.timer01 <= module_stop_control[BIT_TIMER01_STOP];
      module_stopped.timerxy_connection <= module_stop_control[BIT_TIMERXY_STOP];
    end
  end

  // ****************************************
  // edge flags
  // ****************************************
  logic horiz_edge;
  logic horiz_rise;

  assign horiz_edge = internal_horiz_input != horiz_prev;
  assign horiz_rise = internal_horiz_input && !horiz_prev;
  // edges come from clock-sampled levels, never from the raw pins
  assign set_ev[3] = pin_s2[4] && !pin_s3[4];
  assign set_ev[2] = pin_s2[3] && !pin_s3[3];
  assign set_ev[1] = pin_s2[2] && !pin_s3[2];
  assign set_ev[0] = horiz_edge && mask_active;

  // previous horizontal level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      horiz_prev <= 1'b0;
    end else if (ce) begin
      horiz_prev <= internal_horiz_input;
    end
  end

  // set wins over clear; a clear needs a read that returned 1, judged from prdata since a flag may rise after setup
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          flags[gi] <= 1'b0;
          read_seen[gi] <= 1'b0;
        end else if (ce) begin
          if (hw_standby) begin
            flags[gi] <= 1'b0;
            read_seen[gi] <= 1'b0;
          end else if (set_ev[gi]) begin
            flags[gi] <= 1'b1;
          end else if (wr_ok && hit(paddr, OFF_EDGE_SENSE) && !pwdata[gi + 2] && read_seen[gi]) begin
            flags[gi] <= 1'b0;
            read_seen[gi] <= 1'b0;
          end else if (rd_ok && hit(paddr, OFF_EDGE_SENSE) && prdata[gi + 2]) begin
            read_seen[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // free-running timer and mask interval
  // ****************************************
  logic [15:0] frc; // free counter
  logic [15:0] capture; // value caught at horizontal rise
  logic [15:0] mask_lo;
  logic [15:0] mask_hi;
  logic correct_on;

  assign correct_on = decode_ctrl[BIT_CORRECT];
  assign mask_lo = capture + {8'h00, mask_offset_register};
  assign mask_hi = capture + {7'h00, mask_offset_register, 1'b0};

  // counter runs unless its module is stopped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frc <= 16'h0000;
    end else if (ce && !module_stopped.free_timer) begin
      frc <= frc + 16'h0001;
    end
  end

  // capture on rise, suppressed inside a mask when correcting; mask between two matches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capture <= 16'h0000;
      mask_active <= 1'b0;
    end else if (ce && !module_stopped.free_timer) begin
      if (horiz_rise && !(correct_on && mask_active)) begin
        capture <= frc;
        mask_active <= 1'b0;
      end else if (frc == mask_lo) begin
        mask_active <= 1'b1;
      end else if (frc == mask_hi) begin
        mask_active <= 1'b0;
      end
    end
  end

  // corrected horizontal: holds through a mask when correction is on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      horiz_corrected <= 1'b0;
    end else if (ce && !(correct_on && mask_active)) begin
      horiz_corrected <= internal_horiz_input;
    end
  end

  // ****************************************
  // pulse width decoder
  // ****************************************
  logic decode_run; // channel x and connection running
  logic match_armed; // one latch per period
  logic match_b_ev; // compare match b

  assign decode_run = ce && !module_stopped.timerxy_connection;
  assign match_b_ev = match_armed && (timer_counter == compare_b_register);

  // counter clears on horizontal rise when so selected, counts the system clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_counter <= 8'h00;
      match_armed <= 1'b0;
    end else if (decode_run) begin
      if (horiz_rise && decode_ctrl[POS_CLEAR_SEL +: 2] == CLEAR_ON_RISE) begin
        timer_counter <= 8'h00;
        match_armed <= 1'b1;
      end else begin
        if (decode_ctrl[POS_CLOCK_SEL +: 3] == CLOCK_SYSTEM) begin
          timer_counter <= timer_counter + 8'h01;
        end
        if (match_b_ev) begin
          match_armed <= 1'b0;
        end
      end
    end
  end

  // delay latch: horizontal level at the first match after a clear
  // a long pulse still reads 1 at threshold, a short one 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      decoded_pulse_output <= 1'b0;
    end else if (decode_run && match_b_ev && !horiz_rise) begin
      decoded_pulse_output <= internal_horiz_input;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_comp_edge_set: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && set_ev[3] && !hw_standby) |=> flags[3])
    else $error("composite edge did not set its flag");
  a_hfly_edge_set: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pin_s2[3] && !pin_s3[3] && !hw_standby) |=> flags[2])
    else $error("horizontal flyback edge lost");
  a_vfly_edge_set: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pin_s2[2] && !pin_s3[2] && !hw_standby) |=> flags[1])
    else $error("vertical flyback edge lost");
  a_preeq_mask_set: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && horiz_edge && mask_active && !hw_standby) |=> flags[0])
    else $error("edge in mask did not raise pre-equalization flag");
  a_clear_after_read: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(flags[3]) && !$past(hw_standby)) |-> $past(read_seen[3]) && $past(wr_ok))
    else $error("flag cleared without prior read");
  a_level_read: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && psel && !penable && !pwrite && paddr == OFF_EDGE_SENSE) |=>
    prdata[1:0] == {$past(internal_horiz_input), $past(internal_vert_input)})
    else $error("level bits read wrong");
  a_stop_bus_end: assert property (@(posedge ref_clk) disable iff (rst)
    (module_stopped != $past(module_stopped)) |-> !$past(psel))
    else $error("module stop changed inside a bus cycle");
  a_stop_after_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !psel && !hw_standby) |=> module_stopped.timerxy_connection == $past(module_stop_control[BIT_TIMERXY_STOP]))
    else $error("connection stop not applied");
  a_counter_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (decode_run && horiz_rise && decode_ctrl[POS_CLEAR_SEL +: 2] == CLEAR_ON_RISE) |=> timer_counter == 8'h00)
    else $error("counter not cleared on rise");
  a_decode_latch: assert property (@(posedge ref_clk) disable iff (rst)
    (decode_run && match_b_ev && !horiz_rise) |=> decoded_pulse_output == $past(internal_horiz_input))
    else $error("decoded output did not latch level");
  a_mask_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && correct_on && mask_active) |=> $stable(horiz_corrected))
    else $error("edge passed inside mask");
  a_stop_reset: assert property (@(posedge ref_clk) disable iff (rst)
    $past(hw_standby) && $past(ce) |-> module_stop_control == MODULE_STOP_RESET)
    else $error("standby did not restore module stop");

endmodule

// File: verif/sync_source_model.sv
// video sync source model: drives the five sync pins toward the block
// assumes pins change only just after a rising edge of ref_clk
`timescale 1ns/1ps
module sync_source_model
  import sync_edge_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // sync pins toward the block
  output sync_pins_t pins
);
  // all sync lines idle low until a frame is sent
  initial pins = '0;

  // move one pin right after a clock edge
  task automatic set_level(input int idx, input logic val);
    @(posedge ref_clk);
    pins[idx] <= val;
  endtask

  // one frame: rise, hold high, fall, hold low; repeated frames give evenly spaced rises
  task automatic pulse(input int idx, input int high_cyc, input int period_cyc);
    set_level(idx, 1'b1);
    repeat (high_cyc - 1) @(posedge ref_clk);
    set_level(idx, 1'b0);
    repeat (period_cyc - high_cyc - 1) @(posedge ref_clk);
  endtask
endmodule

// File: verif/sync_edge_sense_pwm_decoder_tb_top.sv
// self-checking bench for the sync edge sense and pulse width decoder
// assumes the 32-bit apb slave answers with pready and a sync source model on the pins
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module sync_edge_sense_pwm_decoder_tb_top;
  import sync_edge_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic ref_clk = 1'b0; // 50 mhz system clock
  logic rst = 1'b1; // held for 8 cycles
  logic ce = 1'b1; // always running
  logic hw_standby = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sync_pins_t pins;
  stop_out_t module_stopped;
  logic decoded_pulse_output;
  logic horiz_corrected;
  logic [31:0] rd; // data of the last transfer
  logic se; // error of the last transfer
  int err_total = 0;
  int total_checks = 0;

  // clock: half period 10 ns
  always #10 ref_clk = ~ref_clk;

  sync_edge_decoder u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hw_standby(hw_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .module_stopped(module_stopped), .decoded_pulse_output(decoded_pulse_output),
    .horiz_corrected(horiz_corrected));
  sync_source_model u_src (.ref_clk(ref_clk), .pins(pins));

  // ****************************************
  // shared tasks
  // ****************************************
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the wait for pready is bounded so a dead slave cannot hang the run
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    // look mid-cycle where pready has settled; the next rising edge is the one that completes
    @(negedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      $display("unexpected at %0t: no pready", $time);
      finish_test();
    end else begin
      rd = prdata;
      se = pslverr;
      @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset values and an unmapped address
  task automatic test_reset();
    apb(1'b0, OFF_MODULE_STOP, 32'h0);
    `CHK(rd, {16'h0000, MODULE_STOP_RESET})
    `CHK(module_stopped.free_timer, 1'b1)
    `CHK(module_stopped.timer01, 1'b1)
    `CHK(module_stopped.timerxy_connection, 1'b1)
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[5:2], 4'h0)
    apb(1'b0, 8'h18, 32'h0);
    `CHK({se, rd}, {1'b1, 32'h0})
    $display("test reset done");
  endtask

  // each stop bit alone, then hardware standby restores the reset value
  task automatic test_stop();
    logic [15:0] val [3];
    stop_out_t exp [3];
    val = '{16'h2000, 16'h1000, 16'h0100};
    exp = '{3'b100, 3'b010, 3'b001};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_MODULE_STOP, {16'h0000, val[i]});
      repeat (2) @(posedge ref_clk);
      `CHK(module_stopped, exp[i])
      apb(1'b0, OFF_MODULE_STOP, 32'h0);
      `CHK(rd, {16'h0000, val[i]})
    end
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    apb(1'b0, OFF_MODULE_STOP, 32'h0);
    `CHK(rd, {16'h0000, MODULE_STOP_RESET})
    `CHK(module_stopped, 3'b111)
    apb(1'b1, OFF_MODULE_STOP, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(module_stopped, 3'b000)
    $display("test stop done");
  endtask

  // edge flags: a blind 0 keeps, 1 keeps, 0 after reading 1 clears
  task automatic test_flags();
    int pin_idx [3];
    int fb [3];
    pin_idx = '{4, 3, 2};
    fb = '{BIT_COMPOSITE, BIT_HFLYBACK, BIT_VFLYBACK};
    for (int i = 0; i < 3; i++) begin
      u_src.pulse(pin_idx[i], 4, 10);
      apb(1'b1, OFF_EDGE_SENSE, 32'h0);
      apb(1'b0, OFF_EDGE_SENSE, 32'h0);
      `CHK(rd[fb[i]], 1'b1)
      apb(1'b1, OFF_EDGE_SENSE, 32'h3C);
      apb(1'b0, OFF_EDGE_SENSE, 32'h0);
      `CHK(rd[fb[i]], 1'b1)
      apb(1'b1, OFF_EDGE_SENSE, 32'h0);
      apb(1'b0, OFF_EDGE_SENSE, 32'h0);
      `CHK(rd[fb[i]], 1'b0)
    end
    $display("test flags done");
  endtask

  // live levels of both internal inputs, then with inversion
  task automatic test_levels();
    u_src.set_level(1, 1'b1);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[1:0], 2'b10)
    u_src.set_level(1, 1'b0);
    u_src.set_level(0, 1'b1);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[1:0], 2'b01)
    apb(1'b1, OFF_DECODE_CTRL, 32'h3);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[1:0], 2'b10)
    apb(1'b1, OFF_DECODE_CTRL, 32'h0);
    u_src.set_level(0, 1'b0);
    $display("test levels done");
  endtask

  // mask from offset 8 to 16 after a rise: a lone pulse stays clean, a second rise at 12 flags
  task automatic test_preeq();
    apb(1'b1, OFF_MASK_OFFSET, 32'h8);
    u_src.pulse(1, 3, 40);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    apb(1'b1, OFF_EDGE_SENSE, 32'h0);
    u_src.pulse(1, 3, 40);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[BIT_PREEQ], 1'b0)
    u_src.pulse(1, 3, 12);
    u_src.pulse(1, 3, 40);
    apb(1'b0, OFF_EDGE_SENSE, 32'h0);
    `CHK(rd[BIT_PREEQ], 1'b1)
    $display("test pre-equalization done");
  endtask

  // correction on: a rise outside a mask passes for 3 cycles, a rise inside one is held back
  task automatic test_correct();
    int highs;
    highs = 0;
    apb(1'b1, OFF_DECODE_CTRL, 32'h1 << BIT_CORRECT);
    fork
      u_src.pulse(1, 3, 12);
      repeat (11) begin
        @(negedge ref_clk);
        if (horiz_corrected === 1'b1) begin
          highs++;
        end
      end
    join
    `CHK(highs, 3)
    highs = 0;
    fork
      u_src.pulse(1, 3, 40);
      repeat (12) begin
        @(negedge ref_clk);
        if (horiz_corrected !== 1'b0) begin
          highs++;
        end
      end
    join
    `CHK(highs, 0)
    $display("test correction done");
  endtask

  // threshold of 8 cycles: wide pulses decode as 1, narrow ones as 0
  task automatic test_decoder();
    int width [4];
    logic exp [4];
    width = '{20, 3, 14, 6};
    exp = '{1'b1, 1'b0, 1'b1, 1'b0};
    apb(1'b1, OFF_COMPARE_B, 32'h07);
    apb(1'b1, OFF_DECODE_CTRL, {24'h0, CLOCK_SYSTEM, CLEAR_ON_RISE, 3'b000});
    for (int i = 0; i < 4; i++) begin
      u_src.pulse(1, width[i], 40);
      `CHK(decoded_pulse_output, exp[i])
    end
    $display("test decoder done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_stop();
    test_flags();
    test_levels();
    test_preeq();
    test_correct();
    test_decoder();
    finish_test();
  end
endmodule
